/* lpmc_pkg.sv */
// lpmc_pkg: constants and types shared by the low-power mode controller
// assumes: a single 250 MHz clock domain, synchronous active-high reset
package lpmc_pkg;
    // wishbone register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] CC_OFS = 8'h08;
    localparam logic [7:0] CNT_OFS = 8'h0c;
    // control register fields
    localparam int CTRL_OIE_BIT = 0;
    localparam int CTRL_SLOW_BIT = 1;
    localparam int CTRL_ROM_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    // condition code mask fields and the forced value
    localparam int CC_I0_BIT = 3;
    localparam int CC_I1_BIT = 5;
    localparam logic [1:0] MASK_ALL_ENABLED = 2'h2;
    localparam logic [7:0] CC_RESET = 8'h28;
    // halt opcode
    localparam logic [7:0] HALT_OPCODE = 8'h8e;
    // settle wait in cpu cycles
    localparam logic [12:0] SETTLE_SHORT = 13'h0100;
    localparam logic [12:0] SETTLE_LONG = 13'h1000;
    // stack depth for pushed condition codes
    localparam int STACK_DEPTH = 4;
    localparam int STACK_AW = 2;

    typedef enum logic [4:0] {
        LPMC_RUN = 5'b00001,
        LPMC_WAIT = 5'b00010,
        LPMC_AHALT = 5'b00100,
        LPMC_HALT = 5'b01000,
        LPMC_SETTLE = 5'b10000
    } lpmc_state_t;
endpackage : lpmc_pkg

/* lpmc_stack.sv */
// lpmc_stack: small register-file stack holding pushed condition codes
// assumes: push and pop never in the same cycle; read data registered
`timescale 1ns/1ps
`default_nettype none
module lpmc_stack (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [lpmc_pkg::STACK_AW-1:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [lpmc_pkg::STACK_AW-1:0] raddr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [lpmc_pkg::STACK_DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        rdata_o <= mem[raddr_i];
    end
endmodule : lpmc_stack
`default_nettype wire

/* lpmc_top.sv */
// lpmc_top: low-power mode controller with wait, active halt and halt
// assumes: cpu gives one-cycle instruction strobes, interrupt controller
// gives pending/vector info, option straps are static, wishbone slave regs
// Operation
// - wait instruction stops cpu clock only
// - wait mode forces mask bits to 10
// - wait entry leaves other state untouched
// - wake only on interrupt/reset, load vector
// - push cc, load priority, restore on pop
// - halt enters halt or active halt by enable
// - active halt wake: rtc, rom external, reset
// - no settle wait leaving active halt
// - halt entry forces mask, pending wakes immediately
// - active halt clocks only oscillator and rtc
// - active halt never causes watchdog reset
// - halt switches off oscillator and peripherals
// - halt exit restarts oscillator, waits settle
// - option decides watchdog reset on halt
// - opcode 0x8e decodes as halt
// - after reset run from master clock
// - wait during slow mode gives slow wait
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module lpmc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    // cpu side
    input wire logic wfi_exec_i,
    input wire logic [7:0] opcode_i,
    input wire logic opcode_valid_i,
    input wire logic cc_push_i,
    input wire logic cc_pop_i,
    input wire logic [1:0] irq_priority_i,
    // interrupt controller side
    input wire logic irq_pending_i,
    input wire logic rtc_irq_i,
    input wire logic ext_irq_i,
    input wire logic halt_wake_irq_i,
    input wire logic [15:0] irq_vector_i,
    input wire logic [15:0] reset_vector_i,
    input wire logic wdg_active_i,
    // option straps from outside the clock domain
    input wire logic settle_long_opt_i,
    input wire logic watchdog_stop_option_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // clock gating and cpu control
    output logic cpu_clk_en_o,
    output logic periph_clk_en_o,
    output logic osc_en_o,
    output logic rtc_clk_en_o,
    output logic slow_clk_sel_o,
    output logic pc_load_o,
    output logic [15:0] pc_value_o,
    output logic wdg_reset_o,
    output logic [7:0] condition_code_reg_o
);
    lpmc_pkg::lpmc_state_t state;
    lpmc_pkg::lpmc_state_t next_state;
    logic [2:0] ctrl;
    logic [7:0] cc;
    logic [12:0] settle_cnt;
    logic [12:0] settle_limit;
    localparam int STACK_AW_L = lpmc_pkg::STACK_AW;
    logic [STACK_AW_L-1:0] sp;
    logic [7:0] stack_rdata;
    logic pop_pending;
    logic wake_from_reset;
    logic [2:0] opt_long_sync;
    logic [2:0] opt_wdg_sync;
    logic opt_long;
    logic opt_wdg;
    logic strap_taken;
    logic halt_exec;
    logic wb_req;
    logic wake_now;
    logic sleep_now;

    function automatic logic [7:0] lpmc_set_mask(input logic [7:0] c, input logic [1:0] m);
        logic [7:0] r;
        r = c;
        r[lpmc_pkg::CC_I1_BIT] = m[1];
        r[lpmc_pkg::CC_I0_BIT] = m[0];
        return r;
    endfunction : lpmc_set_mask

    assign halt_exec = opcode_valid_i && (opcode_i == lpmc_pkg::HALT_OPCODE);
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // run exit and entry, seen one edge ahead through the next state
    assign wake_now = (state != lpmc_pkg::LPMC_RUN) && (next_state == lpmc_pkg::LPMC_RUN);
    assign sleep_now = (state == lpmc_pkg::LPMC_RUN) && (next_state != lpmc_pkg::LPMC_RUN);

    // straps pass three flops; a change counts once the last two agree
    // no reset here, so the chain already holds the strap level when reset lifts
    always_ff @(posedge clk_i) begin
        opt_long_sync <= {opt_long_sync[1:0], settle_long_opt_i};
        opt_wdg_sync <= {opt_wdg_sync[1:0], watchdog_stop_option_i};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opt_long <= 1'b0;
            opt_wdg <= 1'b0;
        end else begin
            if (opt_long_sync[2] == opt_long_sync[1]) begin
                opt_long <= opt_long_sync[2];
            end
            if (opt_wdg_sync[2] == opt_wdg_sync[1]) begin
                opt_wdg <= opt_wdg_sync[2];
            end
        end
    end

    // settle length latched once after reset release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_taken <= 1'b0;
            settle_limit <= lpmc_pkg::SETTLE_SHORT;
        end else if (!strap_taken && opt_long_sync[2] == opt_long_sync[1]) begin
            strap_taken <= 1'b1;
            settle_limit <= opt_long_sync[2] ? lpmc_pkg::SETTLE_LONG : lpmc_pkg::SETTLE_SHORT;
        end
    end

    // mode state machine
    always_comb begin
        next_state = state;
        case (state)
            lpmc_pkg::LPMC_RUN: begin
                if (halt_exec) begin
                    next_state = ctrl[lpmc_pkg::CTRL_OIE_BIT] ? lpmc_pkg::LPMC_AHALT : lpmc_pkg::LPMC_HALT;
                end else if (wfi_exec_i) begin
                    next_state = lpmc_pkg::LPMC_WAIT;
                end
            end
            lpmc_pkg::LPMC_WAIT: begin
                if (irq_pending_i) begin
                    next_state = lpmc_pkg::LPMC_RUN;
                end
            end
            lpmc_pkg::LPMC_AHALT: begin
                // rtc always, external only on rom parts
                if (rtc_irq_i || (ctrl[lpmc_pkg::CTRL_ROM_BIT] && ext_irq_i)) begin
                    next_state = lpmc_pkg::LPMC_RUN;
                end
            end
            lpmc_pkg::LPMC_HALT: begin
                // pending wake-capable interrupt leaves at once
                if (halt_wake_irq_i) begin
                    next_state = lpmc_pkg::LPMC_SETTLE;
                end
            end
            lpmc_pkg::LPMC_SETTLE: begin
                if (settle_cnt >= settle_limit - 13'h0001) begin
                    next_state = lpmc_pkg::LPMC_RUN;
                end
            end
            default: begin
                next_state = lpmc_pkg::LPMC_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= lpmc_pkg::LPMC_RUN;
        end else begin
            state <= next_state;
        end
    end

    // reset vector is fetched on the first cycle out of reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_from_reset <= 1'b1;
        end else begin
            wake_from_reset <= 1'b0;
        end
    end

    // counts only in settle; ending one short of the limit gives exactly limit cycles
    always_ff @(posedge clk_i) begin
        if (rst_i || state != lpmc_pkg::LPMC_SETTLE) begin
            settle_cnt <= 13'h0000;
        end else begin
            settle_cnt <= settle_cnt + 13'h0001;
        end
    end

    // the vector is sampled in the cycle the state machine leaves sleep
    // vector load on wake
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_load_o <= 1'b0;
            pc_value_o <= 16'h0000;
        end else if (wake_from_reset) begin
            pc_load_o <= 1'b1;
            pc_value_o <= reset_vector_i;
        end else if (wake_now) begin
            pc_load_o <= 1'b1;
            pc_value_o <= irq_vector_i;
        end else begin
            pc_load_o <= 1'b0;
        end
    end

    // clock gating from next state so outputs track the mode without lag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_clk_en_o <= 1'b1;
            periph_clk_en_o <= 1'b1;
            osc_en_o <= 1'b1;
            rtc_clk_en_o <= 1'b1;
        end else begin
            cpu_clk_en_o <= (next_state == lpmc_pkg::LPMC_RUN);
            // active halt keeps oscillator and rtc only
            periph_clk_en_o <= (next_state == lpmc_pkg::LPMC_RUN) || (next_state == lpmc_pkg::LPMC_WAIT);
            osc_en_o <= (next_state != lpmc_pkg::LPMC_HALT);
            // settle keeps the rtc gated until the oscillator has had its start-up time
            rtc_clk_en_o <= (next_state != lpmc_pkg::LPMC_HALT) && (next_state != lpmc_pkg::LPMC_SETTLE);
        end
    end

    // slow selection is kept through wait
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slow_clk_sel_o <= 1'b0;
        end else begin
            slow_clk_sel_o <= ctrl[lpmc_pkg::CTRL_SLOW_BIT];
        end
    end

    // option gates the halt watchdog reset
    // active halt never resets the watchdog
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdg_reset_o <= 1'b0;
        end else begin
            wdg_reset_o <= (state == lpmc_pkg::LPMC_RUN) && halt_exec && !ctrl[lpmc_pkg::CTRL_OIE_BIT]
                && wdg_active_i && opt_wdg;
        end
    end

    // four entries that wrap: deeper nesting overwrites the oldest saved code
    // condition code stack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sp <= '0;
            pop_pending <= 1'b0;
        end else begin
            pop_pending <= cc_pop_i && !cc_push_i;
            if (cc_push_i) begin
                sp <= sp + STACK_AW_L'(1);
            end else if (cc_pop_i) begin
                sp <= sp - STACK_AW_L'(1);
            end
        end
    end

    lpmc_stack u_stack (
        .clk_i(clk_i),
        .we_i(cc_push_i),
        .waddr_i(sp),
        .wdata_i(cc),
        .raddr_i(sp - STACK_AW_L'(1)),
        .rdata_o(stack_rdata)
    );

    // forcing, push and pop win; a software write in the same cycle is dropped
    // cc changes only through mask forcing, stack or software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cc <= lpmc_pkg::CC_RESET;
        end else if (cc_push_i) begin
            cc <= lpmc_set_mask(cc, irq_priority_i);
        end else if (pop_pending) begin
            cc <= stack_rdata;
        end else if (sleep_now) begin
            // entry to wait, active halt or halt forces mask to 10
            cc <= lpmc_set_mask(cc, lpmc_pkg::MASK_ALL_ENABLED);
        end else if (wb_req && wb_we_i && wb_adr_i == lpmc_pkg::CC_OFS && wb_sel_i[0]) begin
            cc <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            condition_code_reg_o <= lpmc_pkg::CC_RESET;
        end else begin
            condition_code_reg_o <= cc;
        end
    end

    // software control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= lpmc_pkg::CTRL_RESET;
        end else if (wb_req && wb_we_i && wb_adr_i == lpmc_pkg::CTRL_OFS && wb_sel_i[0]) begin
            ctrl <= wb_dat_i[2:0];
        end
    end

    // wishbone answer one cycle after the request, unmapped reads zero
    // writes land on the taking edge, the same edge that raises the ack that reports them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h00000000;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    lpmc_pkg::CTRL_OFS: wb_dat_o <= {29'h0, ctrl};
                    lpmc_pkg::STAT_OFS: wb_dat_o <= {25'h0, opt_wdg, opt_long, state};
                    lpmc_pkg::CC_OFS: wb_dat_o <= {24'h0, cc};
                    lpmc_pkg::CNT_OFS: wb_dat_o <= {19'h0, settle_cnt};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule : lpmc_top
`default_nettype wire

/* lpmc_checker_assertions.sv */
// lpmc_checker: concurrent checks on the ports of lpmc_top
// assumes: bound into lpmc_top, one clock, sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module lpmc_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wfi_exec_i,
    input wire logic [7:0] opcode_i,
    input wire logic opcode_valid_i,
    input wire logic irq_pending_i,
    input wire logic rtc_irq_i,
    input wire logic [15:0] irq_vector_i,
    input wire logic [15:0] reset_vector_i,
    input wire logic wdg_active_i,
    input wire logic settle_long_opt_i,
    input wire logic watchdog_stop_option_i,
    input wire logic cpu_clk_en_o,
    input wire logic periph_clk_en_o,
    input wire logic osc_en_o,
    input wire logic rtc_clk_en_o,
    input wire logic pc_load_o,
    input wire logic [15:0] pc_value_o,
    input wire logic wdg_reset_o,
    input wire logic [7:0] condition_code_reg_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic halt_go, ph, ah, hs;
    logic [12:0] sc;
    logic [12:0] sexp;
    assign halt_go = cpu_clk_en_o && opcode_valid_i && opcode_i == lpmc_pkg::HALT_OPCODE;
    assign sexp = settle_long_opt_i ? lpmc_pkg::SETTLE_LONG : lpmc_pkg::SETTLE_SHORT;
    // ah marks active halt, hs a halt whose oscillator went off
    always_ff @(posedge clk_i) begin
        ph <= !rst_i && halt_go;
        ah <= !rst_i && !cpu_clk_en_o && ((ph && osc_en_o) || ah);
        hs <= !rst_i && !cpu_clk_en_o && (!osc_en_o || hs);
        sc <= (rst_i || !hs) ? 13'h0 : sc + {12'h0, osc_en_o};
    end
    sequence s_wfi_in;
        wfi_exec_i && cpu_clk_en_o && !opcode_valid_i ##1 !cpu_clk_en_o;
    endsequence
    sequence s_halt_in;
        halt_go ##1 !osc_en_o;
    endsequence
    a_reset_run: assert property ($fell(rst_i) |-> ##[0:1] pc_load_o && pc_value_o == reset_vector_i)
        else $error("reset vector not loaded");
    a_wait_stop: assert property (wfi_exec_i && cpu_clk_en_o && !opcode_valid_i |=> !cpu_clk_en_o && periph_clk_en_o)
        else $error("wait did not stop only the cpu");
    a_wait_mask: assert property (s_wfi_in ##1 !cpu_clk_en_o |-> condition_code_reg_o[5] && !condition_code_reg_o[3])
        else $error("mask not forced in wait");
    a_wait_wake: assert property (!cpu_clk_en_o && periph_clk_en_o && irq_pending_i
        |=> cpu_clk_en_o && pc_load_o && pc_value_o == $past(irq_vector_i))
        else $error("wait wake wrong");
    a_wait_hold: assert property (!cpu_clk_en_o && periph_clk_en_o && !irq_pending_i |=> !cpu_clk_en_o)
        else $error("wait left without interrupt");
    a_halt_enter: assert property (halt_go |=> !cpu_clk_en_o && !periph_clk_en_o)
        else $error("halt opcode not taken");
    a_halt_off: assert property (s_halt_in |-> !rtc_clk_en_o)
        else $error("rtc clock runs in halt");
    a_ahalt_wake: assert property (ah && !cpu_clk_en_o && rtc_irq_i |=> cpu_clk_en_o && pc_load_o)
        else $error("active halt wake wrong");
    a_ahalt_nowdg: assert property ((ph && osc_en_o) || ah |-> !wdg_reset_o)
        else $error("watchdog reset in active halt");
    a_halt_wdg: assert property (halt_go && wdg_active_i && watchdog_stop_option_i ##1 !osc_en_o
        |-> ##[0:1] wdg_reset_o)
        else $error("no watchdog reset on halt");
    a_settle_len: assert property ($rose(cpu_clk_en_o) && hs |-> sc + 13'h2 >= sexp && sc <= sexp + 13'h2)
        else $error("settle length wrong");
endmodule : lpmc_checker
`default_nettype wire

/* lpmc_irq_model.sv */
// lpmc_irq_model: interrupt controller beside lpmc_top
// assumes: bench arms it before a sleep instruction, drops arm after wake
`timescale 1ns/1ps
`default_nettype none
module lpmc_irq_model #(
    parameter logic [15:0] VECTOR = 16'h5a3c
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic arm_i,
    input wire logic [1:0] kind_i,
    input wire logic [7:0] delay_i,
    input wire logic cpu_clk_en_i,
    input wire logic pc_load_i,
    output logic irq_pending_o,
    output logic rtc_irq_o,
    output logic ext_irq_o,
    output logic halt_wake_irq_o,
    output logic [15:0] irq_vector_o
);
    logic raised;
    logic [7:0] cnt;
    always_ff @(posedge clk_i) begin
        if (rst_i || pc_load_i) begin
            raised <= 1'b0;
            cnt <= 8'h00;
        end else if (arm_i && !cpu_clk_en_i) begin
            raised <= raised || cnt == delay_i;
            cnt <= cnt + 8'h01;
        end
    end
    assign irq_pending_o = raised;
    assign rtc_irq_o = raised && kind_i == 2'h1;
    assign ext_irq_o = raised && kind_i == 2'h2;
    assign halt_wake_irq_o = raised && kind_i == 2'h3;
    // vector is not held when nothing is raised
    assign irq_vector_o = raised ? VECTOR : ~VECTOR;
endmodule : lpmc_irq_model
`default_nettype wire

/* testbench.sv */
// testbench: drives lpmc_top over wishbone and cpu strobes
// assumes: lpmc_pkg, lpmc_top, lpmc_irq_model, lpmc_checker compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [15:0] IVEC = 16'h5a3c;
    logic clk_i, rst_i, wait_for_interrupt_instr, opv, push, pop, arm, wdg, pend, rtc, ext, hwk;
    logic cyc, stb, we, ack, cpu, per, osc, rtce, slow, pcl, wdr, wso;
    logic [1:0] prio, kind;
    logic [7:0] opc, dly, adr, cco;
    logic [15:0] rvec, ivec, pcv;
    logic [31:0] wdat, rdat;
    logic [31:0] expq[$];
    int errors, compares;
    lpmc_top u_lpmc_top (.clk_i(clk_i), .rst_i(rst_i), .wfi_exec_i(wait_for_interrupt_instr), .opcode_i(opc), .opcode_valid_i(opv),
        .cc_push_i(push), .cc_pop_i(pop), .irq_priority_i(prio), .irq_pending_i(pend), .rtc_irq_i(rtc),
        .ext_irq_i(ext), .halt_wake_irq_i(hwk), .irq_vector_i(ivec), .reset_vector_i(rvec), .wdg_active_i(wdg),
        .settle_long_opt_i(1'b0), .watchdog_stop_option_i(wso), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cpu_clk_en_o(cpu),
        .periph_clk_en_o(per), .osc_en_o(osc), .rtc_clk_en_o(rtce), .slow_clk_sel_o(slow), .pc_load_o(pcl),
        .pc_value_o(pcv), .wdg_reset_o(wdr), .condition_code_reg_o(cco));
    lpmc_irq_model #(.VECTOR(IVEC)) u_lpmc_irq_model (.clk_i(clk_i), .rst_i(rst_i), .arm_i(arm), .kind_i(kind),
        .delay_i(dly), .cpu_clk_en_i(cpu), .pc_load_i(pcl), .irq_pending_o(pend), .rtc_irq_o(rtc),
        .ext_irq_o(ext), .halt_wake_irq_o(hwk), .irq_vector_o(ivec));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            @(posedge clk_i);
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask : rd
    task automatic sleep(input logic h, input logic [1:0] k, input logic osc_irq_enable);
        expq.push_back({16'h0, IVEC});
        kind <= k;
        dly <= 8'($urandom_range(0, 200));
        arm <= 1'b1;
        @(posedge clk_i);
        wait_for_interrupt_instr <= !h;
        opv <= h;
        opc <= lpmc_pkg::HALT_OPCODE;
        @(posedge clk_i);
        wait_for_interrupt_instr <= 1'b0;
        opv <= 1'b0;
        #1;
        chk("cpu", 32'(cpu), 32'h0);
        chk("periph", 32'(per), 32'(!h));
        chk("osc", 32'(osc), 32'(!h || osc_irq_enable));
        chk("wdg reset", 32'(wdr), 32'(h && !osc_irq_enable && wso && wdg));
        while (cpu !== 1'b1) begin
            @(posedge clk_i);
        end
        arm <= 1'b0;
    endtask : sleep
    task automatic final_report;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    // monitor takes the oldest note whenever a read or vector load shows up
    always @(posedge clk_i) begin
        if ((ack === 1'b1 && we === 1'b0) || pcl === 1'b1) begin
            if (expq.size() == 0) chk("extra result", 32'h1, 32'h0);
            else chk("result", pcl ? {16'h0, pcv} : rdat, expq.pop_front());
        end
    end
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        final_report();
    end
    initial begin
        void'($urandom(79422));
        {rst_i, wdg, wso} <= 3'b111;
        {wait_for_interrupt_instr, opv, push, pop, arm, cyc, stb, we} <= 8'h00;
        {prio, kind, opc, dly, adr, wdat} <= '0;
        rvec <= 16'($urandom);
        repeat (8) @(posedge clk_i);
        expq.push_back({16'h0, rvec});
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("enables", {28'h0, cpu, per, osc, rtce}, 32'hf);
        rd(lpmc_pkg::STAT_OFS, 32'h41);
        rd(lpmc_pkg::CTRL_OFS, 32'h0);
        wb(1'b1, 8'h10, 32'hff);
        rd(8'h10, 32'h0);
        wb(1'b1, lpmc_pkg::CC_OFS, 32'h38);
        wb(1'b1, lpmc_pkg::CTRL_OFS, 32'h2);
        sleep(1'b0, 2'h0, 1'b0);
        chk("slow", 32'(slow), 32'h1);
        rd(lpmc_pkg::CC_OFS, 32'h30);
        for (int p = 0; p < 4; p++) begin
            @(posedge clk_i);
            push <= 1'b1;
            prio <= 2'(p);
            @(posedge clk_i);
            push <= 1'b0;
            rd(lpmc_pkg::CC_OFS, 32'h10 | (32'(p[1]) << 5) | (32'(p[0]) << 3));
            pop <= 1'b1;
            @(posedge clk_i);
            pop <= 1'b0;
            repeat (3) @(posedge clk_i);
            rd(lpmc_pkg::CC_OFS, 32'h30);
        end
        wb(1'b1, lpmc_pkg::CC_OFS, 32'h38);
        wb(1'b1, lpmc_pkg::CTRL_OFS, 32'h1);
        sleep(1'b1, 2'h1, 1'b1);
        rd(lpmc_pkg::CC_OFS, 32'h30);
        wb(1'b1, lpmc_pkg::CTRL_OFS, 32'h5);
        sleep(1'b1, 2'h2, 1'b1);
        wb(1'b1, lpmc_pkg::CC_OFS, 32'h38);
        wb(1'b1, lpmc_pkg::CTRL_OFS, 32'h0);
        sleep(1'b1, 2'h3, 1'b0);
        rd(lpmc_pkg::CC_OFS, 32'h30);
        // option low: the same halt must not reset through the watchdog
        wso <= 1'b0;
        repeat (4) @(posedge clk_i);
        sleep(1'b1, 2'h3, 1'b0);
        repeat (4) @(posedge clk_i);
        chk("pending notes", 32'(expq.size()), 32'h0);
        final_report();
    end
endmodule : testbench
bind lpmc_top lpmc_checker u_lpmc_checker (.clk_i, .rst_i, .wfi_exec_i, .opcode_i, .opcode_valid_i,
    .irq_pending_i, .rtc_irq_i, .irq_vector_i, .reset_vector_i, .wdg_active_i, .settle_long_opt_i,
    .watchdog_stop_option_i, .cpu_clk_en_o, .periph_clk_en_o, .osc_en_o, .rtc_clk_en_o, .pc_load_o,
    .pc_value_o, .wdg_reset_o, .condition_code_reg_o);
`default_nettype wire
